// File: inc/vcf_pkg.sv
// Constants and types of the virtual channel framer.
// Assumes one synchronous clock; all lengths count octets.
package vcf_pkg;

    // Frame geometry
    localparam logic [7:0]  SYNC_LEN   = 8'h04;
    localparam logic [7:0]  HDR_LEN    = 8'h06;
    localparam logic [7:0]  DF_LEN     = 8'h40;
    localparam logic [7:0]  TRL_LEN    = 8'h02;
    localparam logic [7:0]  FRAME_LEN  = SYNC_LEN + HDR_LEN + DF_LEN + TRL_LEN;
    localparam logic [7:0]  BODY_LEN   = HDR_LEN + DF_LEN + TRL_LEN;
    localparam logic [7:0]  INS_MAX    = 8'h10;

    // Marker pattern, fill and header fields; values arbitrary
    localparam logic [31:0] SYNC_WORD  = 32'hA5C3_5A3C;
    localparam logic [7:0]  FILL_BYTE  = 8'h55;
    localparam logic [1:0]  HDR_VER    = 2'h1;
    localparam logic [5:0]  VCID_IDLE  = 6'h3F;
    localparam logic [7:0]  HDR_SIG    = 8'h00;

    // Packet wrapper header
    localparam logic [7:0]  PKT_HDR_LEN = 8'h06;
    localparam logic [2:0]  PKT_VER     = 3'h0;
    localparam logic [1:0]  PKT_SEQF    = 2'h3;

    // Grades of service
    localparam logic [1:0]  GOS_1      = 2'h1;
    localparam logic [1:0]  GOS_2      = 2'h2;
    localparam logic [1:0]  GOS_3      = 2'h3;

    // Buffer shape
    localparam int          FIFO_W     = 8;
    localparam int          FIFO_D     = 16;

    typedef enum logic [2:0] {SRC_MUX, SRC_BITS, SRC_VCA, SRC_EXT, SRC_IDLE} vcf_src_e;
    typedef enum logic [2:0] {FR_SYNC, FR_HDR, FR_INS, FR_DATA, FR_TRL, FR_EXT} vcf_fr_e;
    typedef enum logic [1:0] {PK_IDLE, PK_HDR, PK_BODY, PK_PATH} vcf_pk_e;

endpackage : vcf_pkg

// File: hdl/vcf_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; clock enable freezes all state.
module vcf_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   n_q, n_d;
    logic          wr, rd;

    assign in_ready  = (n_q != (AW+1)'(D));
    assign out_valid = (n_q != '0);
    assign out_data  = mem[rp_q];
    assign wr        = ce && in_valid && in_ready;
    assign rd        = ce && out_valid && out_ready;

    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        n_d  = n_q;
        if (wr) begin
            wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
        end
        if (rd) begin
            rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
        end
        if (wr && !rd) begin
            n_d = n_q + 1'b1;
        end else if (rd && !wr) begin
            n_d = n_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            n_q  <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            n_q  <= n_d;
        end
    end

    // Storage carries no reset
    always_ff @(posedge ref_clk) begin
        if (wr) begin
            mem[wp_q] <= in_data;
        end
    end

endmodule : vcf_fifo

// File: hdl/vcf_framer.sv
// Sending side virtual channel framer: builds fixed-length frames on one channel.
// Assumes all inputs synchronous to ref_clk; downstream applies any coding.
// Notes on behaviour
// [R1] Fixed-length frames, each led by marker
// [R2] One channel per frame, grade per channel
// [R3] Header, data field, trailer of fixed length
// [R4] Packets concatenated in order to fill field
// [R5] Foreign units wrapped in packet, in order
// [R6] Bits blocked into field, fill appended
// [R7] Each bitstream owns its channel alone
// [R8] Private units exactly field length, forwarded
// [R9] External frames match own frame length
// [R10] External frames interleaved by configured priority
// [R11] Insert zone in every frame when enabled with nonzero ins_len
// [R12] Insert zone carved from data field
// [R13] Insert zone below 10Mb/s, else bitstream
// [R14] No insert together with external frames
// [R15] Bounded latency and jitter for isochronous data
// [R16] Insert user absorbs its rate mismatch
// [R17] Grade set by configuration, never signalled
// [R18] Grades differ in completeness and errors
// [R19] Receiver may drop units with errors
// [R20] Idle fill frame when nothing ready
// [R21] Spacecraft and channel id in header
// [R22] One ready channel per slot, fixed priority
module vcf_framer
    import vcf_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  scid,
    input  wire logic [5:0]  vcid_mux,
    input  wire logic [5:0]  vcid_bits,
    input  wire logic [5:0]  vcid_vca,
    input  wire logic [1:0]  gos_mux,
    input  wire logic [1:0]  gos_bits,
    input  wire logic [1:0]  gos_vca,
    input  wire logic [1:0]  gos_ext,
    input  wire logic [1:0]  pri_mux,
    input  wire logic [1:0]  pri_bits,
    input  wire logic [1:0]  pri_vca,
    input  wire logic [1:0]  pri_ext,
    input  wire logic [10:0] enc_apid,
    input  wire logic        ins_en,
    input  wire logic [4:0]  ins_len,
    input  wire logic        path_valid,
    output logic             path_ready,
    input  wire logic [7:0]  path_data,
    input  wire logic        path_last,
    input  wire logic        enc_valid,
    output logic             enc_ready,
    input  wire logic [7:0]  enc_data,
    input  wire logic        enc_last,
    input  wire logic [15:0] enc_len,
    input  wire logic        bit_valid,
    output logic             bit_ready,
    input  wire logic        bit_data,
    input  wire logic        vca_valid,
    output logic             vca_ready,
    input  wire logic [7:0]  vca_data,
    input  wire logic        ext_valid,
    output logic             ext_ready,
    input  wire logic [7:0]  ext_data,
    input  wire logic        ins_valid,
    output logic             ins_ready,
    input  wire logic [7:0]  ins_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_sof,
    output logic [1:0]       tx_gos
);

    function automatic logic [5:0] vcid_of(vcf_src_e s, logic [5:0] m, logic [5:0] b,
                                           logic [5:0] v);
        unique case (s)
            SRC_MUX:  vcid_of = m;
            SRC_BITS: vcid_of = b;
            SRC_VCA:  vcid_of = v;
            default:  vcid_of = VCID_IDLE;
        endcase
    endfunction : vcid_of

    // Highest score wins; ties go to the earlier entry
    function automatic vcf_src_e pick(logic [3:0] rdy, logic [7:0] pri);
        logic [2:0] best;
        logic [2:0] sc;
        pick = SRC_IDLE;
        best = 3'h0;
        for (int i = 0; i < 4; i++) begin
            sc = {rdy[i], pri[2*i +: 2]};
            if (rdy[i] && sc > best) begin
                best = sc;
                pick = vcf_src_e'(3'(i));
            end
        end
    endfunction : pick

    // Packet front end: wrapper and pass-through into the mux buffer
    vcf_pk_e     pk_q, pk_d;
    logic [7:0]  pk_idx_q, pk_idx_d;
    logic [15:0] pk_len_q, pk_len_d;
    logic [13:0] pk_seq_q, pk_seq_d;
    logic        pk_push, fifo_irdy, fifo_ovld, fifo_ordy;
    logic [7:0]  pk_byte, fifo_odata;

    always_comb begin
        pk_d = pk_q;
        pk_idx_d = pk_idx_q;
        pk_len_d = pk_len_q;
        pk_seq_d = pk_seq_q;
        pk_push = 1'b0;
        pk_byte = path_data;
        path_ready = 1'b0;
        enc_ready = 1'b0;
        unique case (pk_q)
            PK_IDLE: begin
                if (path_valid) begin
                    pk_d = PK_PATH;
                end else if (enc_valid) begin
                    pk_d = PK_HDR;                                        // R5
                    pk_idx_d = 8'h00;
                    pk_len_d = enc_len + PKT_HDR_LEN[7:0] - 16'h0001;
                end
            end
            PK_HDR: begin
                pk_push = 1'b1;
                unique case (pk_idx_q[2:0])
                    3'h0:    pk_byte = {PKT_VER, 2'b00, enc_apid[10:8]};   // R5
                    3'h1:    pk_byte = enc_apid[7:0];
                    3'h2:    pk_byte = {PKT_SEQF, pk_seq_q[13:8]};
                    3'h3:    pk_byte = pk_seq_q[7:0];
                    3'h4:    pk_byte = pk_len_q[15:8];
                    default: pk_byte = pk_len_q[7:0];
                endcase
                if (fifo_irdy) begin
                    pk_idx_d = pk_idx_q + 8'h01;
                    if (pk_idx_q == PKT_HDR_LEN - 8'h01) begin
                        pk_d = PK_BODY;
                        pk_seq_d = pk_seq_q + 14'h0001;
                    end
                end
            end
            PK_BODY: begin
                pk_push = enc_valid;
                pk_byte = enc_data;
                enc_ready = fifo_irdy;
                if (enc_valid && fifo_irdy && enc_last) begin
                    pk_d = PK_IDLE;
                end
            end
            PK_PATH: begin
                pk_push = path_valid;
                path_ready = fifo_irdy;
                if (path_valid && fifo_irdy && path_last) begin
                    pk_d = PK_IDLE;                                       // R4
                end
            end
        endcase
        if (!ce) begin
            path_ready = 1'b0;
            enc_ready = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pk_q <= PK_IDLE;
            pk_idx_q <= 8'h00;
            pk_len_q <= 16'h0000;
            pk_seq_q <= 14'h0000;
        end else if (ce) begin
            pk_q <= pk_d;
            pk_idx_q <= pk_idx_d;
            pk_len_q <= pk_len_d;
            pk_seq_q <= pk_seq_d;
        end
    end

    vcf_fifo #(.W(FIFO_W), .D(FIFO_D)) u_mux_buf (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .in_valid (pk_push),
        .in_ready (fifo_irdy),
        .in_data  (pk_byte),
        .out_valid(fifo_ovld),
        .out_ready(fifo_ordy),
        .out_data (fifo_odata)
    );

    // Framer state
    vcf_fr_e     st_q, st_d;
    vcf_src_e    src_q, src_d;
    logic [7:0]  idx_q, idx_d, vcnt_q, vcnt_d, chk_q, chk_d;
    logic        fill_q, fill_d;
    logic [23:0] cnt_q [5];
    logic [23:0] cnt_d [5];
    logic [7:0]  obyte_q, obyte_d, byte_c, dz_len, ins_n;
    logic        ovld_q, ovld_d, osof_q, osof_d, adv, avail, take;
    logic [1:0]  ogos_q, ogos_d, gos_c;
    logic [3:0]  rdy;

    // Bitstream packer
    logic [7:0]  bs_sh_q, bs_sh_d, bs_byte_q, bs_byte_d;
    logic [2:0]  bs_n_q, bs_n_d;
    logic        bs_full_q, bs_full_d, bs_acc;

    assign ins_n  = (ins_en && ({3'b000, ins_len} <= INS_MAX)) ? {3'b000, ins_len} // R13
                  : (ins_en ? INS_MAX : 8'h00);
    assign dz_len = DF_LEN - ins_n;                                           // R12
    assign rdy    = {ext_valid && !ins_en, vca_valid, bs_full_q, fifo_ovld};  // R14
    assign adv    = ce && (!ovld_q || tx_ready) && !(st_q == FR_EXT && !ext_valid);
    assign avail  = (src_q == SRC_MUX) ? fifo_ovld
                  : (src_q == SRC_BITS) ? bs_full_q
                  : (src_q == SRC_VCA) ? vca_valid : 1'b0;
    assign take      = adv && st_q == FR_DATA && !fill_q && avail;
    assign fifo_ordy = take && src_q == SRC_MUX;                              // R4
    assign vca_ready = take && src_q == SRC_VCA;                              // R8
    assign ext_ready = adv && st_q == FR_EXT;                                 // R10
    assign ins_ready = adv && st_q == FR_INS;                                 // R11 R15
    assign bit_ready = !(bs_full_q && bs_n_q == 3'h7);
    assign bs_acc    = ce && bit_valid && bit_ready;
    assign gos_c     = (src_d == SRC_MUX) ? gos_mux : (src_d == SRC_BITS) ? gos_bits
                     : (src_d == SRC_VCA) ? gos_vca : (src_d == SRC_EXT) ? gos_ext : GOS_3;

    always_comb begin
        bs_sh_d = bs_sh_q;
        bs_n_d = bs_n_q;
        bs_byte_d = bs_byte_q;
        bs_full_d = bs_full_q;
        if (take && src_q == SRC_BITS) begin
            bs_full_d = 1'b0;
        end
        if (bs_acc) begin
            bs_sh_d = {bs_sh_q[6:0], bit_data};
            bs_n_d = bs_n_q + 3'h1;
            if (bs_n_q == 3'h7) begin
                bs_byte_d = {bs_sh_q[6:0], bit_data};                     // R6
                bs_full_d = 1'b1;
            end
        end
    end

    always_comb begin
        st_d = st_q;
        src_d = src_q;
        idx_d = idx_q;
        fill_d = fill_q;
        vcnt_d = vcnt_q;
        chk_d = chk_q;
        cnt_d = cnt_q;
        obyte_d = obyte_q;
        osof_d = osof_q;
        ogos_d = ogos_q;
        ovld_d = ovld_q && !tx_ready;
        byte_c = FILL_BYTE;
        if (st_q == FR_SYNC && idx_q == 8'h00) begin
            src_d = pick(rdy, {pri_ext, pri_vca, pri_bits, pri_mux});    // R22 R20
        end
        unique case (st_q)
            FR_SYNC: byte_c = 8'(SYNC_WORD >> (8 * (SYNC_LEN - 8'h01 - idx_q)));  // R1
            FR_HDR: begin
                unique case (idx_q[2:0])
                    3'h0:    byte_c = {HDR_VER, scid[7:2]};                  // R21
                    3'h1:    byte_c = {scid[1:0], vcid_of(src_q, vcid_mux, vcid_bits,
                                                          vcid_vca)};   // R2
                    3'h2:    byte_c = cnt_q[src_q][23:16];
                    3'h3:    byte_c = cnt_q[src_q][15:8];
                    3'h4:    byte_c = cnt_q[src_q][7:0];
                    default: byte_c = HDR_SIG;                               // R17
                endcase
            end
            FR_INS:  byte_c = ins_valid ? ins_data : FILL_BYTE;              // R16
            FR_DATA: begin
                if (!fill_q && avail) begin
                    byte_c = (src_q == SRC_MUX) ? fifo_odata
                           : (src_q == SRC_BITS) ? bs_byte_q : vca_data;
                end
            end
            FR_TRL:  byte_c = (idx_q == 8'h00) ? vcnt_q : chk_q;            // R19
            FR_EXT:  byte_c = ext_data;
        endcase
        if (adv) begin
            ovld_d = 1'b1;
            obyte_d = byte_c;
            osof_d = (st_q == FR_SYNC && idx_q == 8'h00);
            ogos_d = gos_c;                                                  // R18
            idx_d = idx_q + 8'h01;
            if (st_q != FR_SYNC && st_q != FR_EXT) begin
                chk_d = chk_q ^ byte_c;
            end
            unique case (st_q)
                FR_SYNC: begin
                    if (idx_q == SYNC_LEN - 8'h01) begin
                        idx_d = 8'h00;
                        chk_d = 8'h00;
                        vcnt_d = 8'h00;
                        fill_d = 1'b0;
                        st_d = (src_q == SRC_EXT) ? FR_EXT : FR_HDR;
                    end
                end
                FR_HDR: begin
                    if (idx_q == HDR_LEN - 8'h01) begin
                        idx_d = 8'h00;
                        cnt_d[src_q] = cnt_q[src_q] + 24'h000001;
                        st_d = (ins_n != 8'h00) ? FR_INS : FR_DATA;          // R11
                    end
                end
                FR_INS: begin
                    if (idx_q == ins_n - 8'h01) begin
                        idx_d = 8'h00;
                        st_d = FR_DATA;
                    end
                end
                FR_DATA: begin
                    if (take) begin
                        vcnt_d = vcnt_q + 8'h01;
                    end else begin
                        fill_d = 1'b1;                                      // R6 R20
                    end
                    if (idx_q == dz_len - 8'h01) begin
                        idx_d = 8'h00;
                        st_d = FR_TRL;                                       // R3
                    end
                end
                FR_TRL: begin
                    if (idx_q == TRL_LEN - 8'h01) begin
                        idx_d = 8'h00;
                        st_d = FR_SYNC;
                    end
                end
                FR_EXT: begin
                    if (idx_q == BODY_LEN - 8'h01) begin
                        idx_d = 8'h00;
                        st_d = FR_SYNC;                                      // R9
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= FR_SYNC;
            src_q <= SRC_IDLE;
            idx_q <= 8'h00;
            fill_q <= 1'b0;
            vcnt_q <= 8'h00;
            chk_q <= 8'h00;
            for (int i = 0; i < 5; i++) begin
                cnt_q[i] <= 24'h000000;
            end
            obyte_q <= 8'h00;
            ovld_q <= 1'b0;
            osof_q <= 1'b0;
            ogos_q <= GOS_3;
            bs_sh_q <= 8'h00;
            bs_n_q <= 3'h0;
            bs_byte_q <= 8'h00;
            bs_full_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            src_q <= src_d;
            idx_q <= idx_d;
            fill_q <= fill_d;
            vcnt_q <= vcnt_d;
            chk_q <= chk_d;
            cnt_q <= cnt_d;
            obyte_q <= obyte_d;
            ovld_q <= ovld_d;
            osof_q <= osof_d;
            ogos_q <= ogos_d;
            bs_sh_q <= bs_sh_d;
            bs_n_q <= bs_n_d;
            bs_byte_q <= bs_byte_d;
            bs_full_q <= bs_full_d;
        end
    end

    assign tx_valid = ovld_q;
    assign tx_data  = obyte_q;
    assign tx_sof   = osof_q;
    assign tx_gos   = ogos_q;

    // Checks
    logic [7:0] hs_cnt_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hs_cnt_q <= 8'h00;
        end else if (ce && tx_valid && tx_ready) begin
            hs_cnt_q <= tx_sof ? 8'h01 : hs_cnt_q + 8'h01;
        end
    end

    sequence enc_begin;
        ce && pk_q == PK_IDLE && !path_valid && enc_valid;
    endsequence
    sequence enc_first_byte;
        pk_push && pk_byte[7:5] == PKT_VER && pk_q == PK_HDR;
    endsequence

    sof_marker_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R1
        tx_valid && tx_sof |-> tx_data == SYNC_WORD[31:24])
        else $error("frame start without marker byte");
    frame_len_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R1
        ce && tx_valid && tx_ready && tx_sof && hs_cnt_q != 8'h00 |-> hs_cnt_q == FRAME_LEN)
        else $error("frame length differs from fixed length");
    hdr_vcid_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R21
        adv && st_q == FR_HDR && idx_q == 8'h01 |=>
        obyte_q[5:0] == vcid_of(src_q, vcid_mux, vcid_bits, vcid_vca))
        else $error("header channel id mismatch");
    ins_zone_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
        adv && st_q == FR_HDR && idx_q == HDR_LEN - 8'h01 && ins_n != 8'h00 |=> st_q == FR_INS)
        else $error("insert zone skipped");
    data_zone_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
        adv && st_q == FR_DATA && idx_q == dz_len - 8'h01 |=> st_q == FR_TRL && idx_q == 8'h00)
        else $error("data zone length wrong");
    ext_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
        st_q == FR_SYNC && idx_q == 8'h00 && ins_en |-> src_d != SRC_EXT)
        else $error("external frame chosen with insert on");
    idle_pick_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R20
        adv && st_q == FR_SYNC && idx_q == 8'h00 && rdy == 4'h0 |=> src_q == SRC_IDLE)
        else $error("idle frame not chosen");
    ext_prio_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
        adv && st_q == FR_SYNC && idx_q == 8'h00 && rdy[3] && pri_ext > pri_mux &&
        pri_ext > pri_bits && pri_ext > pri_vca |=> src_q == SRC_EXT)
        else $error("priority external frame not chosen");
    mux_excl_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
        fifo_ordy || (take && src_q == SRC_BITS) |-> st_q == FR_DATA && !fill_q)
        else $error("source byte taken outside its data zone");
    fill_tail_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R6
        adv && st_q == FR_DATA && fill_q |=> obyte_q == FILL_BYTE && ovld_q)
        else $error("fill not emitted after underrun");
    enc_hdr_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R5
        enc_begin |=> enc_first_byte)
        else $error("wrapper header does not lead unit");

endmodule : vcf_framer

// File: tb/vcf_tx_sink.sv
// Output link partner: takes tx octets with a stall every fourth cycle.
// Assumes the framer output is on ref_clk; keeps the last whole frame.
module vcf_tx_sink (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_sof,
    input  wire logic [1:0] tx_gos,
    output logic [7:0]      frm [76],
    output logic [1:0]      gos,
    output int              nfr,
    output logic            len_err
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx = 76;
    int st  = 0;
    initial begin
        tx_ready = 1'b0;
        nfr = 0;
        len_err = 1'b0;
    end
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            idx = 76;
        end else if (ce && tx_valid && tx_ready) begin
            if (tx_sof) begin
                len_err |= (idx != 76);
                idx = 0;
                gos = tx_gos;
            end
            if (idx < 76) frm[idx] = tx_data;
            idx++;
            if (idx == 76) nfr++;
        end
        st++;
        #1 tx_ready = (st % 4) != 3;
    end
endmodule : vcf_tx_sink

// File: tb/tb.sv
// Self-checking bench: one source per table row, then a reset one clock after a frame ends.
// Assumes the sink model captures whole frames from the output link.
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb;
    import vcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int src; int hd; int n; int il; logic [5:0] vc; logic [1:0] gs;} vcf_row_s;
    vcf_row_s rows [7] = '{'{0, 0, 0, 0, VCID_IDLE, 2'h3}, '{1, 0, 64, 0, 6'h33, 2'h1},
        '{2, 0, 1, 0, 6'h22, 2'h2}, '{3, 0, 64, 0, 6'h11, 2'h1}, '{5, 6, 16, 0, 6'h11, 2'h1},
        '{1, 0, 60, 4, 6'h33, 2'h3}, '{4, 0, 72, 0, 6'h00, 2'h2}};
    logic       ref_clk, arst_n, ce, ins_en, len_err, hs, hi;
    logic [1:0] gos_mux, gos_bits, gos_vca, gos_ext, pri_mux, pri_bits, pri_vca, pri_ext;
    logic       path_ready, enc_ready, bit_ready, vca_ready, ext_ready, ins_ready;
    logic       tx_valid, tx_ready, tx_sof;
    logic [7:0] scid, tx_data, x, ex, bb;
    logic [7:0] frm [76];
    logic [4:0] ins_len;
    logic [1:0] gos, tx_gos;
    int         nfr, bad_count, checks, sel, n, idx, ii, j;
    wire        v = (sel != 0) && (idx < (sel == 2 ? 8 * n : n));
    wire [7:0]  d = idx[7:0];
    assign bb = idx[10:3];
    wire        bd = bb[3'h7 - idx[2:0]];
    wire        rdy = sel == 1 ? vca_ready : sel == 2 ? bit_ready : sel == 3 ? path_ready :
                      sel == 4 ? ext_ready : enc_ready;
    vcf_framer DUT (.ref_clk, .arst_n, .ce, .scid, .vcid_mux(6'h11), .vcid_bits(6'h22),
        .vcid_vca(6'h33), .gos_mux, .gos_bits, .gos_vca, .gos_ext,
        .pri_mux, .pri_bits, .pri_vca, .pri_ext, .enc_apid(11'h5A3),
        .ins_en, .ins_len, .path_valid(v && sel == 3), .path_ready, .path_data(d),
        .path_last(idx[3:0] == 4'hF), .enc_valid(v && sel == 5), .enc_ready, .enc_data(d),
        .enc_last(idx == n - 1), .enc_len(16'h0010), .bit_valid(v && sel == 2), .bit_ready,
        .bit_data(bd), .vca_valid(v && sel == 1), .vca_ready, .vca_data(d),
        .ext_valid(v && sel == 4), .ext_ready, .ext_data(d), .ins_valid(ins_en), .ins_ready,
        .ins_data(ii[7:0]), .tx_valid, .tx_ready, .tx_data, .tx_sof, .tx_gos);
    vcf_tx_sink sink (.ref_clk, .arst_n, .ce, .tx_valid, .tx_ready, .tx_data, .tx_sof, .tx_gos,
        .frm, .gos, .nfr, .len_err);
    task automatic stop_test;
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic wait_frames(input int c);
        int k0;
        k0 = nfr;
        for (int t = 0; t < 2000 && nfr < k0 + c; t++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK("frame count", k0 + c, nfr)
    endtask : wait_frames
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Source feeder: one octet or bit per handshake
    always begin
        @(posedge ref_clk);
        hs = v && rdy;
        hi = ins_en && ins_ready;
        #1;
        if (hs) idx++;
        if (hi) ii++;
    end
    initial begin
        #200000;
        bad_count++;
        stop_test;
    end
    initial begin
        {arst_n, ins_en, ins_len, scid, sel, n, idx, ii, bad_count, checks} = '0;
        ce = 1'b1;
        {gos_mux, gos_bits, gos_vca, gos_ext} = 8'h66;
        {pri_ext, pri_vca, pri_bits, pri_mux} = 8'hE4;
        repeat (6) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        foreach (rows[r]) begin
            sel = rows[r].src;
            n = rows[r].n;
            idx = 0;
            scid = 8'hC0 + 8'(r);
            ins_en = rows[r].il != 0;
            ins_len = 5'(rows[r].il);
            if (rows[r].src == 1) gos_vca = rows[r].gs;
            wait_frames(2);
            for (int i = 0; i < 4; i++) `CHK("marker", SYNC_WORD[31-8*i -: 8], frm[i])
            `CHK("grade", rows[r].gs, gos)
            if (rows[r].src == 4) begin
                for (int i = 0; i < 72; i++) `CHK("ext octet", 8'(i), frm[4+i])
            end else begin
                `CHK("hdr0", {HDR_VER, scid[7:2]}, frm[4])
                `CHK("hdr1", {scid[1:0], rows[r].vc}, frm[5])
                x = 8'h00;
                for (int i = 4; i < 75; i++) x ^= frm[i];
                `CHK("trailer sum", x, frm[75])
                `CHK("data count", 8'(rows[r].hd + rows[r].n), frm[74])
                for (int i = 0; i < rows[r].il; i++) `CHK("insert", frm[10] + 8'(i), frm[10+i])
                for (int i = rows[r].il + rows[r].hd; i < 64; i++) begin
                    j = i - rows[r].il - rows[r].hd;
                    ex = j < rows[r].n ? 8'(j) : FILL_BYTE;
                    `CHK("field", ex, frm[10+i])
                end
                if (rows[r].hd != 0) `CHK("wrap length", 8'h15, frm[15])
            end
        end
        sel = 0;
        // Clock enable low: output must hold the fresh marker byte
        ce = 1'b0;
        x = tx_data;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("freeze", x, tx_data)
        ce = 1'b1;
        wait_frames(1);
        @(posedge ref_clk);
        #1 arst_n = 1'b0;
        #2;
        `CHK("reset valid", 1'b0, tx_valid)
        `CHK("reset grade", 2'h3, tx_gos)
        @(posedge ref_clk);
        #1 arst_n = 1'b1;
        wait_frames(2);
        `CHK("frame length", 1'b0, len_err)
        stop_test;
    end
endmodule : tb
